// ---- shared/sysint_pkg.sv ----
// Package: offsets, reset values, field layouts and carriers of the
// system configuration and protection register bank.
// Assumes a single 250 MHz clock domain and a simple strobe register port.
package sysint_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_AUTOVEC = 8'h04;
  localparam logic [7:0] OFS_RST_CAUSE = 8'h08;
  localparam logic [7:0] OFS_WD_VECTOR = 8'h0C;
  localparam logic [7:0] OFS_PROT_CTRL = 8'h10;
  localparam logic [7:0] OFS_WD_SERVICE = 8'h14;
  localparam logic [7:0] OFS_PRESCALE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_CONFIG = 16'h00FF;
  localparam logic [7:0] RST_AUTOVEC = 8'h00;
  localparam logic [7:0] RST_WD_VECTOR = 8'h0F;
  localparam logic [7:0] RST_PROT_CTRL = 8'hF0;
  localparam logic RST_PRESCALE = 1'b1;
  localparam logic [7:0] POWER_UP_CAUSE = 8'hC0;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_SHOW_LSB = 8;
  localparam int CFG_SUPERVISOR_ONLY_BIT = 7;
  localparam int CFG_BCLR_LSB = 4;
  localparam int PROT_WD_EN = 7;
  localparam int PROT_ACTION = 6;
  localparam int PROT_TIMING_LSB = 4;
  localparam int RC_EXT = 7;
  localparam int RC_POW = 6;
  localparam int RC_WD = 5;
  localparam int RC_DBF = 4;
  localparam int RC_LOC = 2;
  localparam int RC_INSN = 1;
  localparam int RC_PIN = 0;
  localparam logic [7:0] RC_MASK = 8'hF7;
  // ------------------------------------------------------------
  // Fixed values and counts
  // ------------------------------------------------------------
  localparam logic [3:0] REFRESH_ARB_LEVEL = 4'h6;
  localparam logic [2:0] WD_IRQ_LEVEL = 3'h7;
  localparam logic [7:0] SERVICE_KEY1 = 8'h55;
  localparam logic [7:0] SERVICE_KEY2 = 8'hAA;
  localparam int WD_PRESCALE_DIV = 512;
  localparam int WD_BASE_LOG2 = 9;
  localparam int WD_COUNT_W = 16;

  typedef enum logic [1:0] {SHOW_OFF, SHOW_NO_ARB, SHOW_ARB_A, SHOW_ARB_B} show_mode_t;
  typedef enum {SVC_IDLE, SVC_ARMED} svc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic done;
    logic power_up;
    logic external;
    logic watchdog;
    logic double_fault;
    logic clock_loss;
    logic reset_insn;
    logic soft_pin;
  } reset_event_t;
endpackage

// ---- src/sysint_regs.sv ----
// System configuration and protection register bank with watchdog.
// Assumes register strobes come from ref_clk logic; pins are asynchronous.
//
// Function
// - 00: split buses, arbitration on
// - 01: show cycles, no arbitration, no grant
// - 1x: show cycles, arbitration, halt on grant
// - Slave mode forces show select to 00
// - Supervisor bit stored, no effect
// - Normal mode: clear-out when level exceeds mask
// - Slave mode: lower internal master releases bus
// - Refresh arbitration level fixed at six
// - Arbitration id soft_reset_pin to F
// - Autovector per enabled external level
// - Autovector only with nonzero arbitration id
// - Cause updated at reset end, power-up loads C0
// - Cause bits write-one-to-clear
// - Cause bit layout fixed
// - Clock-loss flag needs enable and loop
// - Reset-instruction flag invalid when core disabled
// - Watchdog vector read-write, soft_reset_pin to 0F
// - Protection control writable once per reset
// - Watchdog enable soft_reset_pin to one
// - Timeout: level-7 interrupt or system reset
// - Timing select default 11 is longest
// - Timeout 2^9..2^15, prescaled 2^18..2^24
// - New timing effective after 55 then AA
// - Prescale divides watchdog clock by 512
module sysint_regs
  import sysint_pkg::*;
#(
  parameter int WD_BASE = sysint_pkg::WD_BASE_LOG2,
  parameter int WD_PRE_DIV = sysint_pkg::WD_PRESCALE_DIV
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire sysint_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  input wire logic power_on_rst,
  input wire sysint_pkg::reset_event_t rst_evt,
  input wire logic clock_loss_reset_enable,
  input wire logic osc_loop_enable,
  input wire logic slave_mode_pin,
  input wire logic ext_bus_req_pin,
  input wire logic bus_clear_in,
  input wire logic [2:0] irq_service_level,
  input wire logic int_master_req,
  input wire logic [3:0] int_master_level,
  input wire logic iack_cycle,
  input wire logic [2:0] iack_level,
  input wire logic wd_clk_tick,
  output logic show_cycles_en,
  output logic ext_arb_en,
  output logic bus_grant_out,
  output logic internal_halt,
  output logic bus_clear_out,
  output logic int_master_release,
  output logic [3:0] refresh_arb_level,
  output logic autovector_response,
  output logic [2:0] wd_irq_level,
  output logic wd_irq,
  output logic [7:0] wd_irq_vector,
  output logic wd_reset_req
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic slave_mode;
  logic ext_req;
  logic bclr_in;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else if (clk_en) begin
      pin_meta_q <= {slave_mode_pin, ext_bus_req_pin, bus_clear_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign slave_mode = pin_sync_q[2];
  assign ext_req = pin_sync_q[1];
  assign bclr_in = pin_sync_q[0];

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic wr_config;
  logic wr_autovec;
  logic wr_cause;
  logic wr_vector;
  logic wr_prot;
  logic wr_service;
  logic wr_prescale;

  assign wr_config = reg_req.wr && hit(reg_req.addr, OFS_CONFIG);
  assign wr_autovec = reg_req.wr && hit(reg_req.addr, OFS_AUTOVEC);
  assign wr_cause = reg_req.wr && hit(reg_req.addr, OFS_RST_CAUSE);
  assign wr_vector = reg_req.wr && hit(reg_req.addr, OFS_WD_VECTOR);
  assign wr_prot = reg_req.wr && hit(reg_req.addr, OFS_PROT_CTRL);
  assign wr_service = reg_req.wr && hit(reg_req.addr, OFS_WD_SERVICE);
  assign wr_prescale = reg_req.wr && hit(reg_req.addr, OFS_PRESCALE);

  // ------------------------------------------------------------
  // Configuration, autovector, vector, protection registers
  // ------------------------------------------------------------
  logic [15:0] config_q;
  logic [7:0] autovec_q;
  logic [7:0] vector_q;
  logic [7:0] prot_q;
  logic prot_locked_q;
  logic prescale_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      config_q <= RST_CONFIG;
      autovec_q <= RST_AUTOVEC;
      vector_q <= RST_WD_VECTOR;
      prot_q <= RST_PROT_CTRL;
      prot_locked_q <= 1'b0;
      prescale_q <= RST_PRESCALE;
    end else if (clk_en) begin
      if (wr_config) begin
        config_q <= {6'h0, reg_req.wdata[9:0]};
      end
      if (wr_autovec) begin
        autovec_q <= {reg_req.wdata[7:1], 1'b0};
      end
      if (wr_vector) begin
        vector_q <= reg_req.wdata[7:0];
      end
      if (wr_prot && !prot_locked_q) begin
        prot_q <= reg_req.wdata[7:0];
        prot_locked_q <= 1'b1;
      end
      if (wr_prescale) begin
        prescale_q <= reg_req.wdata[0];
      end
    end
  end

  // ------------------------------------------------------------
  // Bus configuration decode
  // ------------------------------------------------------------
  show_mode_t show_sel;
  logic [2:0] bclr_field;
  logic [3:0] iarb;

  // Slave mode ignores the stored value but keeps it for a later mode change
  assign show_sel = slave_mode ? SHOW_OFF
                  : show_mode_t'(config_q[CFG_SHOW_LSB +: 2]);
  assign bclr_field = config_q[CFG_BCLR_LSB +: 3];
  assign iarb = config_q[3:0];

  assign show_cycles_en = show_sel != SHOW_OFF;
  assign ext_arb_en = show_sel != SHOW_NO_ARB;
  assign refresh_arb_level = REFRESH_ARB_LEVEL;

  logic grant_q;
  logic bclr_out_q;
  logic release_q;
  logic autovector_response_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      grant_q <= 1'b0;
      bclr_out_q <= 1'b0;
      release_q <= 1'b0;
      autovector_response_q <= 1'b0;
    end else if (clk_en) begin
      grant_q <= ext_arb_en && ext_req;
      bclr_out_q <= !slave_mode && (irq_service_level > bclr_field);
      // Priority 7 would let every internal master below level 7 be cleared off the bus
      release_q <= slave_mode && bclr_in && int_master_req
                   && (int_master_level < {1'b0, bclr_field});
      autovector_response_q <= iack_cycle && (iack_level != 3'h0)
                && autovec_q[iack_level] && (iarb != 4'h0);
    end
  end

  assign bus_grant_out = grant_q;
  assign internal_halt = grant_q && show_sel[1];
  assign bus_clear_out = bclr_out_q;
  assign int_master_release = release_q;
  assign autovector_response = autovector_response_q;

  // ------------------------------------------------------------
  // Reset cause register
  // ------------------------------------------------------------
  logic [7:0] cause_q;
  logic [7:0] cause_new;
  logic [7:0] cause_clr;

  assign cause_new[RC_EXT] = rst_evt.external || rst_evt.power_up;
  assign cause_new[RC_POW] = rst_evt.power_up;
  assign cause_new[RC_WD] = rst_evt.watchdog;
  assign cause_new[RC_DBF] = rst_evt.double_fault;
  assign cause_new[3] = 1'b0;
  assign cause_new[RC_LOC] = rst_evt.clock_loss && clock_loss_reset_enable
                             && osc_loop_enable;
  assign cause_new[RC_INSN] = rst_evt.reset_insn && !slave_mode;
  assign cause_new[RC_PIN] = rst_evt.soft_pin;
  assign cause_clr = wr_cause ? reg_req.wdata[7:0] : 8'h00;

  // Not cleared by sys_rst, so software can read the cause afterwards
  always_ff @(posedge ref_clk) begin
    if (power_on_rst) begin
      cause_q <= POWER_UP_CAUSE;
    end else if (clk_en) begin
      if (rst_evt.done) begin
        cause_q <= cause_new & RC_MASK;
      end else begin
        cause_q <= cause_q & ~cause_clr & RC_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // Watchdog service sequence and timing latch
  // ------------------------------------------------------------
  svc_state_t svc_q;
  svc_state_t svc_d;
  logic svc_done;
  logic [1:0] timing_act_q;
  logic prescale_act_q;

  always_comb begin
    svc_d = svc_q;
    svc_done = 1'b0;
    case (svc_q)
      SVC_IDLE: begin
        if (wr_service && reg_req.wdata[7:0] == SERVICE_KEY1) begin
          svc_d = SVC_ARMED;
        end
      end
      SVC_ARMED: begin
        if (wr_service) begin
          svc_done = reg_req.wdata[7:0] == SERVICE_KEY2;
          svc_d = (reg_req.wdata[7:0] == SERVICE_KEY1) ? SVC_ARMED : SVC_IDLE;
        end
      end
      default: svc_d = SVC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      svc_q <= SVC_IDLE;
      timing_act_q <= RST_PROT_CTRL[PROT_TIMING_LSB +: 2];
      prescale_act_q <= RST_PRESCALE;
    end else if (clk_en) begin
      svc_q <= svc_d;
      if (svc_done) begin
        timing_act_q <= prot_q[PROT_TIMING_LSB +: 2];
        prescale_act_q <= prescale_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Watchdog prescaler and timeout counter
  // ------------------------------------------------------------
  localparam int PRE_W = $clog2(WD_PRE_DIV);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(WD_PRE_DIV - 1);

  logic [PRE_W-1:0] pre_q;
  logic [WD_COUNT_W-1:0] wd_cnt_q;
  logic [WD_COUNT_W-1:0] wd_limit;
  logic wd_step;
  logic wd_timeout;
  logic wd_en;
  logic wd_irq_q;
  logic wd_rst_q;

  assign wd_en = prot_q[PROT_WD_EN];
  // Timeout = 2^(base + 2*timing) steps; prescale multiplies by 2^9
  assign wd_limit = WD_COUNT_W'((32'd1 << (WD_BASE + 2 * int'(timing_act_q))) - 1);
  assign wd_step = wd_clk_tick && (!prescale_act_q || pre_q == PRE_LAST);
  assign wd_timeout = wd_en && wd_step && wd_cnt_q == wd_limit;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_q <= '0;
      wd_cnt_q <= '0;
      wd_irq_q <= 1'b0;
      wd_rst_q <= 1'b0;
    end else if (clk_en) begin
      if (!wd_en || svc_done) begin
        pre_q <= '0;
        wd_cnt_q <= '0;
      end else begin
        if (wd_clk_tick && prescale_act_q) begin
          pre_q <= pre_q + PRE_W'(1);
        end
        if (wd_step) begin
          wd_cnt_q <= wd_timeout ? '0 : wd_cnt_q + WD_COUNT_W'(1);
        end
      end
      // Interrupt level holds until serviced; a new timeout wins the clear
      if (wd_timeout && !prot_q[PROT_ACTION]) begin
        wd_irq_q <= 1'b1;
      end else if (svc_done) begin
        wd_irq_q <= 1'b0;
      end
      wd_rst_q <= wd_timeout && prot_q[PROT_ACTION];
    end
  end

  assign wd_irq = wd_irq_q;
  assign wd_irq_level = WD_IRQ_LEVEL;
  assign wd_irq_vector = vector_q;
  assign wd_reset_req = wd_rst_q;

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  logic [15:0] rd_mux;
  logic [15:0] rdata_q;

  always_comb begin
    case (reg_req.addr)
      OFS_CONFIG: rd_mux = {6'h0, show_sel, config_q[7:0]};
      OFS_AUTOVEC: rd_mux = {8'h0, autovec_q};
      OFS_RST_CAUSE: rd_mux = {8'h0, cause_q};
      OFS_WD_VECTOR: rd_mux = {8'h0, vector_q};
      OFS_PROT_CTRL: rd_mux = {8'h0, prot_q};
      OFS_PRESCALE: rd_mux = {15'h0, prescale_q};
      OFS_STATUS: rd_mux = {12'h0, wd_irq_q, prot_locked_q, slave_mode, grant_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else if (clk_en) begin
      rdata_q <= reg_req.rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// ---- testbench/sysint_core_model.sv ----
// Core-side model: watchdog input ticks and interrupt acknowledges.
// Assumes the bench gates ticks through tick_on and calls iack.
module sysint_core_model (
  input wire logic ref_clk,
  output logic wd_clk_tick,
  output logic iack_cycle,
  output logic [2:0] iack_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tick_on;
  logic half;
  initial begin
    tick_on = 1'b0;
    half = 1'b0;
    wd_clk_tick = 1'b0;
    iack_cycle = 1'b0;
    iack_level = 3'h0;
  end
  // Tick at half rate so a count never matches the clock by accident
  always @(posedge ref_clk) begin
    half <= ~half;
    wd_clk_tick <= tick_on & half;
  end
  task automatic iack(input logic [2:0] lvl);
    @(posedge ref_clk);
    iack_cycle <= 1'b1;
    iack_level <= lvl;
    @(posedge ref_clk);
    iack_cycle <= 1'b0;
    iack_level <= ~lvl;
    #1;
  endtask
endmodule

// ---- testbench/sysint_regs_properties.sv ----
// Port checker for the configuration and protection register bank.
// Assumes one ref_clk domain and a synchronous sys_rst.
module sysint_regs_chk
  import sysint_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire sysint_pkg::reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] irq_service_level,
  input wire logic bus_clear_out,
  input wire logic ext_arb_en,
  input wire logic bus_grant_out,
  input wire logic internal_halt,
  input wire logic [3:0] refresh_arb_level,
  input wire logic [2:0] wd_irq_level,
  input wire logic wd_reset_req,
  input wire logic iack_cycle,
  input wire logic [2:0] iack_level,
  input wire logic autovector_response,
  input wire logic [7:0] wd_irq_vector
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_refresh; refresh_arb_level == 4'h6; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh level moved");
  property p_irq_lvl; wd_irq_level == 3'h7; endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("watchdog level moved");
  property p_rd_idle; !$past(reg_req.rd) |-> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_vec_rd;
    $past(reg_req.rd) && $past(reg_req.addr) == OFS_WD_VECTOR
      |-> reg_rdata == {8'h00, wd_irq_vector};
  endproperty
  a_vec_rd: assert property (p_vec_rd) else $error("vector read mismatch");
  property p_bclr; bus_clear_out |-> $past(irq_service_level) != 3'h0; endproperty
  a_bclr: assert property (p_bclr) else $error("clear-out at level zero");
  property p_rst_req; wd_reset_req |=> !wd_reset_req; endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request too long");
  property p_grant; bus_grant_out |-> $past(ext_arb_en); endproperty
  a_grant: assert property (p_grant) else $error("grant without arbitration");
  property p_halt; internal_halt |-> bus_grant_out; endproperty
  a_halt: assert property (p_halt) else $error("halt without grant");
  property p_autovector_response;
    autovector_response |-> $past(iack_cycle) && $past(iack_level) != 3'h0;
  endproperty
  a_autovector_response: assert property (p_autovector_response) else $error("autovector without acknowledge");
endmodule

bind sysint_regs sysint_regs_chk u_chk (.ref_clk, .sys_rst, .reg_req, .reg_rdata,
  .irq_service_level, .bus_clear_out, .ext_arb_en, .bus_grant_out, .internal_halt,
  .refresh_arb_level, .wd_irq_level, .wd_reset_req, .iack_cycle, .iack_level,
  .autovector_response, .wd_irq_vector);

// ---- testbench/sysint_regs_tb_top.sv ----
// Self-checking bench for the configuration and protection register bank.
// Assumes the core model drives ticks and acknowledges; one 250 MHz clock.
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module sysint_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sysint_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, power_on_rst = 1'b1, clk_en = 1'b1;
  reg_req_t reg_req = '0;
  reset_event_t rst_evt = '0;
  logic clock_loss_reset_enable = 1'b0, osc_loop_enable = 1'b0, slave_mode_pin = 1'b0;
  logic ext_bus_req_pin = 1'b0, bus_clear_in = 1'b0, int_master_req = 1'b0;
  logic [2:0] irq_service_level = 3'h0;
  logic [3:0] int_master_level = 4'h0;
  logic [15:0] reg_rdata;
  logic wd_clk_tick, iack_cycle, show_cycles_en, ext_arb_en, bus_grant_out, internal_halt;
  logic bus_clear_out, int_master_release, autovector_response, wd_irq, wd_reset_req;
  logic [2:0] iack_level, wd_irq_level;
  logic [3:0] refresh_arb_level;
  logic [7:0] wd_irq_vector;
  int fails = 0, comparisons = 0, cycles = 0;
  logic [7:0] ra [7] = '{OFS_CONFIG, OFS_AUTOVEC, OFS_RST_CAUSE, OFS_WD_VECTOR,
    OFS_PROT_CTRL, OFS_PRESCALE, 8'h20};
  logic [15:0] rv [7] = '{16'h00FF, 16'h0000, 16'h00C0, 16'h000F, 16'h00F0, 16'h0001,
    16'h0000};
  logic [7:0] ev [6] = '{8'hC0, 8'hA0, 8'h90, 8'h88, 8'h82, 8'h81};
  logic [15:0] ce [6] = '{16'h00C0, 16'h0080, 16'h0020, 16'h0010, 16'h0002, 16'h0001};

  sysint_core_model core (.ref_clk, .wd_clk_tick, .iack_cycle, .iack_level);
  sysint_regs #(.WD_BASE(1), .WD_PRE_DIV(4)) DUT (.ref_clk, .sys_rst, .clk_en,
    .reg_req, .reg_rdata, .power_on_rst, .rst_evt, .clock_loss_reset_enable,
    .osc_loop_enable, .slave_mode_pin, .ext_bus_req_pin, .bus_clear_in,
    .irq_service_level, .int_master_req, .int_master_level, .iack_cycle, .iack_level,
    .wd_clk_tick, .show_cycles_en, .ext_arb_en, .bus_grant_out, .internal_halt,
    .bus_clear_out, .int_master_release, .refresh_arb_level, .autovector_response,
    .wd_irq_level, .wd_irq, .wd_irq_vector, .wd_reset_req);

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // Run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    reg_req <= '{~a, ~d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge ref_clk);
    reg_req <= '{~a, 16'hFFFF, 1'b0, 1'b0};
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic evt(input logic [7:0] v, input logic [15:0] e);
    @(posedge ref_clk);
    rst_evt <= v;
    @(posedge ref_clk);
    rst_evt <= '0;
    rd(OFS_RST_CAUSE, e);
  endtask
  task automatic svc();
    wr(OFS_WD_SERVICE, 16'h0055);
    wr(OFS_WD_SERVICE, 16'h00AA);
  endtask
  task automatic sysreset();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    power_on_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    `CHK("refresh_arb_level", 4'h6, refresh_arb_level)
    `CHK("wd_irq_level", 3'h7, wd_irq_level)
    wr(OFS_RST_CAUSE, 16'h0040);
    rd(OFS_RST_CAUSE, 16'h0080);
    wr(OFS_RST_CAUSE, 16'h0000);
    rd(OFS_RST_CAUSE, 16'h0080);
    for (int i = 0; i < 6; i++) evt(ev[i], ce[i]);
    evt(8'h84, 16'h0000);
    @(posedge ref_clk);
    clock_loss_reset_enable <= 1'b1;
    osc_loop_enable <= 1'b1;
    evt(8'h84, 16'h0004);
    wr(OFS_RST_CAUSE, 16'h00FF);
    rd(OFS_RST_CAUSE, 16'h0000);
    wr(OFS_AUTOVEC, 16'h0005);
    rd(OFS_AUTOVEC, 16'h0004);
    core.iack(3'h2);
    `CHK("autovector_response", 1'b1, autovector_response)
    core.iack(3'h3);
    `CHK("autovector_response", 1'b0, autovector_response)
    wr(OFS_CONFIG, 16'h0020);
    core.iack(3'h2);
    `CHK("autovector_response", 1'b0, autovector_response)
    wr(OFS_CONFIG, 16'h002F);
    irq_service_level <= 3'h3;
    cyc(2);
    `CHK("bus_clear_out", 1'b1, bus_clear_out)
    @(posedge ref_clk);
    irq_service_level <= 3'h2;
    cyc(2);
    `CHK("bus_clear_out", 1'b0, bus_clear_out)
    @(posedge ref_clk);
    ext_bus_req_pin <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CONFIG, {6'h00, 2'(i), 8'h2F});
      cyc(4);
      `CHK("bus_grant_out", i != 1, bus_grant_out)
      `CHK("internal_halt", i == 2, internal_halt)
      `CHK("ext_arb_en", i != 1, ext_arb_en)
      `CHK("show_cycles_en", i != 0, show_cycles_en)
    end
    @(posedge ref_clk);
    slave_mode_pin <= 1'b1;
    ext_bus_req_pin <= 1'b0;
    irq_service_level <= 3'h7;
    bus_clear_in <= 1'b1;
    int_master_req <= 1'b1;
    int_master_level <= 4'h1;
    wr(OFS_CONFIG, 16'h032F);
    cyc(4);
    rd(OFS_CONFIG, 16'h002F);
    `CHK("show_cycles_en", 1'b0, show_cycles_en)
    `CHK("bus_clear_out", 1'b0, bus_clear_out)
    `CHK("int_master_release", 1'b1, int_master_release)
    @(posedge ref_clk);
    int_master_level <= 4'h2;
    cyc(2);
    `CHK("int_master_release", 1'b0, int_master_release)
    evt(8'h82, 16'h0000);
    @(posedge ref_clk);
    slave_mode_pin <= 1'b0;
    bus_clear_in <= 1'b0;
    int_master_req <= 1'b0;
    sysreset();
    rd(OFS_RST_CAUSE, 16'h0000);
    wr(OFS_WD_VECTOR, 16'h005A);
    wr(OFS_PROT_CTRL, 16'h0080);
    wr(OFS_PRESCALE, 16'h0000);
    svc();
    core.tick_on <= 1'b1;
    repeat (100) begin
      if (wd_irq === 1'b1) break;
      cyc(1);
    end
    `CHK("wd_irq", 1'b1, wd_irq)
    `CHK("wd_irq_vector", 8'h5A, wd_irq_vector)
    @(posedge ref_clk);
    core.tick_on <= 1'b0;
    // Frozen clock enable must drop the write
    clk_en <= 1'b0;
    wr(OFS_WD_VECTOR, 16'h00A5);
    clk_en <= 1'b1;
    rd(OFS_WD_VECTOR, 16'h005A);
    wr(OFS_PRESCALE, 16'h0001);
    svc();
    #1;
    `CHK("wd_irq", 1'b0, wd_irq)
    @(posedge ref_clk);
    core.tick_on <= 1'b1;
    cyc(8);
    `CHK("wd_irq", 1'b0, wd_irq)
    repeat (100) begin
      if (wd_irq === 1'b1) break;
      cyc(1);
    end
    `CHK("wd_irq", 1'b1, wd_irq)
    @(posedge ref_clk);
    core.tick_on <= 1'b0;
    sysreset();
    wr(OFS_PROT_CTRL, 16'h00C0);
    wr(OFS_PROT_CTRL, 16'h0000);
    rd(OFS_PROT_CTRL, 16'h00C0);
    wr(OFS_PRESCALE, 16'h0000);
    core.tick_on <= 1'b1;
    svc();
    repeat (100) begin
      if (wd_reset_req === 1'b1) break;
      cyc(1);
    end
    `CHK("wd_reset_req", 1'b1, wd_reset_req)
    test_done();
  end
endmodule
